// File: src/sar_readout_consts.svh
// Timing and format constants for the converter readout block.
// Assumes a 50 MHz core clock; included by bare name.
`ifndef SAR_READOUT_CONSTS_SVH
`define SAR_READOUT_CONSTS_SVH

`define CORE_CLK_MHZ 50
`define RESULT_BITS 16
// Least conversion time in ns, and its cycle count rounded up
`define CONV_TIME_NS 172
`define CONV_CYCLES ((`CONV_TIME_NS * `CORE_CLK_MHZ + 999) / 1000)
`define BIT_CNT_W 5
`define FIFO_DEPTH 4

`endif

// File: src/sar_readout_pkg.sv
// Types for the converter readout block.
// Assumes nothing beyond a SystemVerilog compiler.
package sar_readout_pkg;
    typedef enum logic [1:0] {
        MODE_CMOS = 2'h0,
        MODE_LVDS = 2'h1,
        MODE_LVDS_LOW_POWER = 2'h2
    } io_mode_t;

    typedef enum logic [2:0] {
        ST_SAMPLE = 3'h1,
        ST_CONVERT = 3'h2,
        ST_WAIT = 3'h4
    } phase_t;
endpackage

// File: src/result_fifo.sv
// Small valid/ready FIFO held in flip-flops.
// Assumes a single clock and an active-low asynchronous reset.
module result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    assign in_ready_o = (count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (push) begin
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
        end
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule // result_fifo

// File: src/pin_sync.sv
// Two-flop synchroniser for a bus of pin inputs.
// Assumes the inputs are asynchronous to core_clk_i.
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule // pin_sync

// File: src/sar_adc_serial_readout.sv
// Conversion control and serial readout of a 16-bit differential converter.
// Assumes the host drives the convert strobe and shift clock as pins, and the
// converter core presents a signed result word at each end of conversion.
`include "sar_readout_consts.svh"

// Functional notes
// - Strobe high means sampling the input
// - Strobe fall starts conversion, enables output
// - Shift clock fall presents next bit, MSB first
// - Mode pin low CMOS, high LVDS
// - Floating mode pin gives low-power LVDS
// - Strobe behaves same in every mode
// - CMOS drives only positive data output
// - LVDS drives data differentially, host differential clock
// - Strobe rise releases data output quickly
// - Strobe fall drives first bit without clock
// - Shifted bits are previous conversion result
// - Result is a 16-bit word at conversion end
// - Result word is two's complement
module sar_adc_serial_readout #(
    parameter int RESULT_W = `RESULT_BITS,
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic convert_strobe_n_i,
    input wire logic shift_clk_pos_i,
    input wire logic shift_clk_neg_i,
    input wire logic mode_pin_low_i,
    input wire logic mode_pin_high_i,
    input wire logic signed [RESULT_W-1:0] core_result_i,
    output logic sampling_o,
    output logic converting_o,
    output logic [1:0] io_mode_o,
    output logic serial_result_out_pos_o,
    output logic serial_result_out_pos_oe_o,
    output logic serial_result_out_neg_o,
    output logic serial_result_out_neg_oe_o,
    output logic result_dropped_o
);
    // ==========================================================
    // Pin synchronisers
    logic [4:0] pins_sync;
    logic strobe_s, sck_pos_s, sck_neg_s, mode_lo_s, mode_hi_s;

    pin_sync #(.WIDTH(5)) u_sync (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .async_i({convert_strobe_n_i, shift_clk_pos_i, shift_clk_neg_i,
                  mode_pin_low_i, mode_pin_high_i}),
        .sync_o(pins_sync)
    );
    assign {strobe_s, sck_pos_s, sck_neg_s, mode_lo_s, mode_hi_s} = pins_sync;

    // ==========================================================
    // Signalling mode decode
    sar_readout_pkg::io_mode_t mode, next_mode;
    logic sck_level;

    always_comb begin
        // Both sense inputs low: pin tied to ground
        if (!mode_lo_s && !mode_hi_s) begin
            next_mode = sar_readout_pkg::MODE_CMOS;
        end else if (mode_lo_s && mode_hi_s) begin
            next_mode = sar_readout_pkg::MODE_LVDS;
        end else begin
            next_mode = sar_readout_pkg::MODE_LVDS_LOW_POWER;
        end
    end

    // CMOS takes the positive clock alone; LVDS takes the difference
    assign sck_level = (mode == sar_readout_pkg::MODE_CMOS) ? sck_pos_s
                     : (sck_pos_s && !sck_neg_s);

    // ==========================================================
    // Edge detection
    logic strobe_d, sck_d, next_strobe_d, next_sck_d;
    logic strobe_fall, strobe_rise, sck_fall;

    assign next_strobe_d = strobe_s;
    assign next_sck_d = sck_level;
    assign strobe_fall = strobe_d && !strobe_s;
    assign strobe_rise = !strobe_d && strobe_s;
    assign sck_fall = sck_d && !sck_level;

    // ==========================================================
    // Conversion phase machine and result path
    sar_readout_pkg::phase_t phase, next_phase;
    logic [5:0] conv_cnt, next_conv_cnt;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [RESULT_W-1:0] fifo_out_data;
    logic next_sampling, next_converting, next_dropped;

    always_comb begin
        next_phase = phase;
        next_conv_cnt = conv_cnt;
        fifo_in_valid = 1'b0;
        unique case (phase)
            sar_readout_pkg::ST_SAMPLE: begin
                if (strobe_fall) begin
                    next_phase = sar_readout_pkg::ST_CONVERT;
                    next_conv_cnt = 6'(`CONV_CYCLES);
                end
            end
            sar_readout_pkg::ST_CONVERT: begin
                if (conv_cnt > 6'h1) begin
                    next_conv_cnt = conv_cnt - 6'h1;
                end else begin
                    // New word enters the queue for readout at the next strobe fall
                    fifo_in_valid = 1'b1;
                    next_phase = strobe_s ? sar_readout_pkg::ST_SAMPLE
                                          : sar_readout_pkg::ST_WAIT;
                end
            end
            sar_readout_pkg::ST_WAIT: begin
                if (strobe_s) begin
                    next_phase = sar_readout_pkg::ST_SAMPLE;
                end
            end
        endcase
        next_sampling = (next_phase == sar_readout_pkg::ST_SAMPLE);
        next_converting = (next_phase == sar_readout_pkg::ST_CONVERT);
        next_dropped = fifo_in_valid && !fifo_in_ready;
    end

    result_fifo #(.WIDTH(RESULT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(core_result_i),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_out_data)
    );

    // ==========================================================
    // Serial shifter
    logic [RESULT_W-1:0] shift_reg, next_shift_reg;
    logic [`BIT_CNT_W-1:0] bits_left, next_bits_left;
    logic drive, next_drive;
    logic next_pos, next_pos_oe, next_neg, next_neg_oe;

    always_comb begin
        next_shift_reg = shift_reg;
        next_bits_left = bits_left;
        next_drive = drive;
        fifo_pop = 1'b0;
        if (strobe_rise) begin
            next_drive = 1'b0;
        end else if (strobe_fall) begin
            // Previous result goes out, first bit without a clock edge
            next_drive = 1'b1;
            next_bits_left = `BIT_CNT_W'(RESULT_W);
            if (fifo_out_valid) begin
                next_shift_reg = fifo_out_data;
                fifo_pop = 1'b1;
            end
        end else if (drive && sck_fall && bits_left != '0) begin
            next_shift_reg = {shift_reg[RESULT_W-2:0], 1'b0};
            next_bits_left = bits_left - `BIT_CNT_W'(1);
        end
        next_pos = next_shift_reg[RESULT_W-1];
        next_pos_oe = next_drive;
        next_neg = !next_shift_reg[RESULT_W-1];
        next_neg_oe = next_drive && (next_mode != sar_readout_pkg::MODE_CMOS);
    end

    // ==========================================================
    // State registers
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode <= sar_readout_pkg::MODE_CMOS;
            io_mode_o <= 2'h0;
            strobe_d <= 1'b0;
            sck_d <= 1'b0;
            phase <= sar_readout_pkg::ST_SAMPLE;
            conv_cnt <= 6'h0;
            sampling_o <= 1'b1;
            converting_o <= 1'b0;
            result_dropped_o <= 1'b0;
            shift_reg <= '0;
            bits_left <= '0;
            drive <= 1'b0;
            serial_result_out_pos_o <= 1'b0;
            serial_result_out_pos_oe_o <= 1'b0;
            serial_result_out_neg_o <= 1'b1;
            serial_result_out_neg_oe_o <= 1'b0;
        end else begin
            mode <= next_mode;
            io_mode_o <= next_mode;
            strobe_d <= next_strobe_d;
            sck_d <= next_sck_d;
            phase <= next_phase;
            conv_cnt <= next_conv_cnt;
            sampling_o <= next_sampling;
            converting_o <= next_converting;
            result_dropped_o <= next_dropped;
            shift_reg <= next_shift_reg;
            bits_left <= next_bits_left;
            drive <= next_drive;
            serial_result_out_pos_o <= next_pos;
            serial_result_out_pos_oe_o <= next_pos_oe;
            serial_result_out_neg_o <= next_neg;
            serial_result_out_neg_oe_o <= next_neg_oe;
        end
    end

endmodule // sar_adc_serial_readout

// File: verification/sar_readout_checker.sv
// Port-level assertions for the converter readout block.
// Assumes binding to sar_adc_serial_readout and the 50 MHz core clock.
module sar_readout_checker (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic convert_strobe_n_i,
    input wire logic shift_clk_pos_i,
    input wire logic mode_pin_low_i,
    input wire logic mode_pin_high_i,
    input wire logic sampling_o,
    input wire logic converting_o,
    input wire logic [1:0] io_mode_o,
    input wire logic serial_result_out_pos_o,
    input wire logic serial_result_out_pos_oe_o,
    input wire logic serial_result_out_neg_o,
    input wire logic serial_result_out_neg_oe_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    // ==========================================================
    // Strobe sequences
    sequence strobe_low_held;
        $fell(convert_strobe_n_i) ##1 !convert_strobe_n_i [*4];
    endsequence
    sequence strobe_high_held;
        $rose(convert_strobe_n_i) ##1 convert_strobe_n_i [*4];
    endsequence

    // ==========================================================
    // Properties
    a_drive_on_fall: assert property (strobe_low_held |-> serial_result_out_pos_oe_o)
        else $error("data not driven after strobe fall");
    a_conv_on_fall: assert property (strobe_low_held |-> converting_o)
        else $error("no conversion after strobe fall");
    a_release_on_rise: assert property (strobe_high_held |->
        !serial_result_out_pos_oe_o && !serial_result_out_neg_oe_o)
        else $error("data not released after strobe rise");
    a_sample_phase: assert property (convert_strobe_n_i [*5] |-> sampling_o)
        else $error("not sampling while strobe high");
    a_cmos_neg_idle: assert property (io_mode_o == sar_readout_pkg::MODE_CMOS |->
        !serial_result_out_neg_oe_o)
        else $error("negative output driven in cmos mode");
    a_lvds_neg_drive: assert property (io_mode_o != sar_readout_pkg::MODE_CMOS &&
        serial_result_out_pos_oe_o |-> serial_result_out_neg_oe_o)
        else $error("negative output idle in lvds mode");
    a_diff_pair: assert property (serial_result_out_neg_oe_o |->
        serial_result_out_neg_o == !serial_result_out_pos_o)
        else $error("data pair not complementary");
    a_mode_cmos: assert property ((!mode_pin_low_i && !mode_pin_high_i) [*5] |->
        io_mode_o == sar_readout_pkg::MODE_CMOS)
        else $error("grounded mode pin not cmos");
    a_mode_lvds: assert property ((mode_pin_low_i && mode_pin_high_i) [*5] |->
        io_mode_o == sar_readout_pkg::MODE_LVDS)
        else $error("raised mode pin not lvds");
    a_mode_float: assert property ((mode_pin_low_i != mode_pin_high_i) [*5] |->
        io_mode_o == sar_readout_pkg::MODE_LVDS_LOW_POWER)
        else $error("floating mode pin not low power");
    a_bits_stand: assert property ((!convert_strobe_n_i && shift_clk_pos_i) [*4] ##0
        !$past(convert_strobe_n_i, 5) |-> $stable(serial_result_out_pos_o))
        else $error("data moved without shift clock fall");
endmodule // sar_readout_checker

bind sar_adc_serial_readout sar_readout_checker chk (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .convert_strobe_n_i(convert_strobe_n_i),
    .shift_clk_pos_i(shift_clk_pos_i), .mode_pin_low_i(mode_pin_low_i),
    .mode_pin_high_i(mode_pin_high_i), .sampling_o(sampling_o), .converting_o(converting_o),
    .io_mode_o(io_mode_o), .serial_result_out_pos_o(serial_result_out_pos_o),
    .serial_result_out_pos_oe_o(serial_result_out_pos_oe_o),
    .serial_result_out_neg_o(serial_result_out_neg_o),
    .serial_result_out_neg_oe_o(serial_result_out_neg_oe_o));

// File: verification/host_model.sv
// Host side: drives strobe and shift clock, captures result bits.
// Assumes the 50 MHz core clock; shift clock period 160 ns.
module host_model (
    input wire logic core_clk_i,
    input wire logic lvds_i,
    input wire logic data_pos_i,
    input wire logic data_oe_i,
    output logic strobe_n_o,
    output logic sck_pos_o,
    output logic sck_neg_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic idle_tog = 1'b0;
    initial begin
        strobe_n_o = 1'b1;
        sck_pos_o = 1'b1;
    end
    always @(posedge core_clk_i) idle_tog <= ~idle_tog;
    // Unconnected pin in cmos wanders; complement clock in lvds
    assign sck_neg_o = lvds_i ? ~sck_pos_o : idle_tog;

    // ==========================================================
    // One conversion frame of sixteen falls
    task automatic run_frame(output logic [15:0] word, output logic oe_first);
        @(posedge core_clk_i) strobe_n_o <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        oe_first = data_oe_i;
        for (int i = 15; i >= 0; i--) begin
            word[i] = data_pos_i;
            sck_pos_o <= 1'b0;
            repeat (4) @(posedge core_clk_i);
            sck_pos_o <= 1'b1;
            repeat (4) @(posedge core_clk_i);
        end
        strobe_n_o <= 1'b1;
    endtask
endmodule // host_model

// File: verification/sar_adc_serial_readout_tb_top.sv
// Testbench for the converter readout block with a host model.
// Assumes the design and package sources are compiled first.
module sar_adc_serial_readout_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic mode_pin_low_i = 1'b0;
    logic mode_pin_high_i = 1'b0;
    logic signed [15:0] core_result_i = 16'h0000;
    logic strobe_n, sck_pos, sck_neg, sampling, converting, pos, pos_oe, neg, neg_oe;
    logic [1:0] io_mode;
    logic [15:0] prev, cur, word;
    logic [15:0] corner [4] = '{16'h8000, 16'h7fff, 16'hffff, 16'h0001};
    logic oe_first;
    logic dropped;
    logic [1:0] pins;
    int unsigned seed_val;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;

    always #10 core_clk_i = ~core_clk_i;

    sar_adc_serial_readout dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .convert_strobe_n_i(strobe_n), .shift_clk_pos_i(sck_pos), .shift_clk_neg_i(sck_neg),
        .mode_pin_low_i(mode_pin_low_i), .mode_pin_high_i(mode_pin_high_i),
        .core_result_i(core_result_i), .sampling_o(sampling), .converting_o(converting),
        .io_mode_o(io_mode), .serial_result_out_pos_o(pos), .serial_result_out_pos_oe_o(pos_oe),
        .serial_result_out_neg_o(neg), .serial_result_out_neg_oe_o(neg_oe),
        .result_dropped_o(dropped));

    host_model host (.core_clk_i(core_clk_i), .lvds_i(mode_pin_low_i | mode_pin_high_i),
        .data_pos_i(pos), .data_oe_i(pos_oe), .strobe_n_o(strobe_n), .sck_pos_o(sck_pos),
        .sck_neg_o(sck_neg));

    // ==========================================================
    // Checking helpers
    function automatic logic [1:0] expected_mode(input logic [1:0] p);
        if (p == 2'b00) return sar_readout_pkg::MODE_CMOS;
        if (p == 2'b11) return sar_readout_pkg::MODE_LVDS;
        return sar_readout_pkg::MODE_LVDS_LOW_POWER;
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 10000) begin
            err_count++;
            $display("[ERR] %0t run too long", $time);
            report_and_stop();
        end
    end

    // ==========================================================
    // Frames in every mode, corner words then random words
    initial begin
        seed_val = $urandom(32'h093c);
        repeat (8) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        prev = 16'h0000;
        for (int f = 0; f < 12; f++) begin
            pins = (f < 4) ? 2'(f) : 2'($urandom_range(3));
            cur = (f < 4) ? corner[f] : 16'($urandom);
            mode_pin_low_i <= pins[0];
            mode_pin_high_i <= pins[1];
            core_result_i <= cur;
            repeat (6) @(posedge core_clk_i);
            check(16'(io_mode), 16'(expected_mode(pins)), "mode");
            check(16'(sampling), 16'h0001, "sampling");
            host.run_frame(word, oe_first);
            check(16'(oe_first), 16'h0001, "first bit drive");
            check(word, prev, "word");
            repeat (6) @(posedge core_clk_i);
            check(16'({pos_oe, neg_oe}), 16'h0000, "release");
            check(16'({converting, dropped}), 16'h0000, "idle after frame");
            prev = cur;
        end
        report_and_stop();
    end
endmodule // sar_adc_serial_readout_tb_top
